/* File: hdl/tml_pkg.sv */
// Constants, register layout and types of the terminal mode line handler.
// Assumes a 32-bit classic Wishbone slave port and byte-wide character streams.
package tml_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] ADDR_LINE_CTRL = 4'h0;
  localparam logic [3:0] ADDR_NL_SEL = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;

  localparam logic [7:0] LINE_CTRL_RESET = 8'h27;
  localparam logic [7:0] LINE_CTRL_MASK = 8'h2F;
  localparam logic [7:0] NL_SEL_RESET = 8'h11;
  localparam logic [7:0] NL_SEL_MASK = 8'hFF;

  // ****************************************************************
  // Field codes
  // ****************************************************************
  localparam logic [1:0] DEL_SEND_DEL = 2'h0;
  localparam logic [1:0] DEL_SEND_ERASE = 2'h1;

  localparam logic [3:0] ONL_NONE = 4'h0;
  localparam logic [3:0] ONL_CR_LF = 4'h1;
  localparam logic [3:0] ONL_NUL = 4'h2;
  localparam logic [3:0] ONL_CR = 4'h3;
  localparam logic [3:0] ONL_LF_CR = 4'h4;
  localparam logic [3:0] ONL_LF = 4'h5;

  localparam logic [3:0] INL_CR = 4'h1;
  localparam logic [3:0] INL_NUL = 4'h2;

  // ****************************************************************
  // Characters
  // ****************************************************************
  localparam logic [7:0] CH_NUL = 8'h00;
  localparam logic [7:0] CH_BKSP = 8'h08;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_DEL = 8'h7F;

  localparam int MARK_LEN = 5;
  localparam logic [39:0] MARK_CHARS = 40'h5B5359535D;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [1:0] rsv_hi;
    logic edit_en;
    logic rsv_lo;
    logic [1:0] del_mode;
    logic echo_en;
    logic ready_en;
  } tml_line_ctrl_t;

  typedef struct packed {
    logic [3:0] out_nl;
    logic [3:0] in_nl;
  } tml_nl_sel_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CHAR,
    ST_ERASE,
    ST_ECHO_NL,
    ST_MARK,
    ST_MARK_NL,
    ST_MSG_NL
  } tml_state_t;

endpackage

/* File: hdl/tml_line_handler.sv */
// Terminal mode line handler: console character processing and output framing.
// Assumes rx and message streams come from logic on clk_i; tx is drained by a UART.
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps

module tml_line_handler (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  input wire logic [7:0] msg_data_i,
  input wire logic msg_last_i,
  input wire logic msg_valid_i,
  output logic msg_ready_o,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output logic line_done_o
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic [1:0] nl_len(input logic [3:0] code);
    case (code)
      tml_pkg::ONL_CR_LF, tml_pkg::ONL_LF_CR: nl_len = 2'h2;
      tml_pkg::ONL_NUL, tml_pkg::ONL_CR, tml_pkg::ONL_LF: nl_len = 2'h1;
      default: nl_len = 2'h0; // Reserved codes append nothing
    endcase
  endfunction
  function automatic logic [7:0] nl_char(input logic [3:0] code, input logic [2:0] idx);
    case (code)
      tml_pkg::ONL_CR_LF: nl_char = (idx == 3'h0) ? tml_pkg::CH_CR : tml_pkg::CH_LF;
      tml_pkg::ONL_LF_CR: nl_char = (idx == 3'h0) ? tml_pkg::CH_LF : tml_pkg::CH_CR;
      tml_pkg::ONL_CR: nl_char = tml_pkg::CH_CR;
      tml_pkg::ONL_LF: nl_char = tml_pkg::CH_LF;
      default: nl_char = tml_pkg::CH_NUL;
    endcase
  endfunction

  // ****************************************************************
  // Registers and bus slave
  // ****************************************************************
  tml_pkg::tml_line_ctrl_t ctrl_q;
  tml_pkg::tml_nl_sel_t nlsel_q;
  tml_pkg::tml_state_t state_q;
  logic [7:0] lines_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic buf_in_ready, buf_out_valid, wr_strobe;
  logic [31:0] rdata_d;
  localparam int MARK_LAST = tml_pkg::MARK_LEN - 1;
  // Write lands on the edge where the master sees ack
  assign wr_strobe = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= tml_pkg::LINE_CTRL_RESET;
      nlsel_q <= tml_pkg::NL_SEL_RESET;
    end
    else if (wr_strobe && wb_adr_i == tml_pkg::ADDR_LINE_CTRL)
      ctrl_q <= wb_dat_i[7:0] & tml_pkg::LINE_CTRL_MASK;
    else if (wr_strobe && wb_adr_i == tml_pkg::ADDR_NL_SEL)
      nlsel_q <= wb_dat_i[7:0] & tml_pkg::NL_SEL_MASK;
  end

  always_comb
  begin
    case (wb_adr_i)
      tml_pkg::ADDR_LINE_CTRL: rdata_d = {24'h000000, ctrl_q};
      tml_pkg::ADDR_NL_SEL: rdata_d = {24'h000000, nlsel_q};
      tml_pkg::ADDR_STATUS:
        rdata_d = {16'h0000, lines_q, 6'h00, buf_out_valid, state_q != tml_pkg::ST_IDLE};
      default: rdata_d = 32'h00000000;
    endcase
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
      rdata_q <= rdata_d;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // ****************************************************************
  // Character sequencer
  // ****************************************************************
  logic [7:0] ch_q;
  logic [2:0] idx_q;
  logic [7:0] push_data;
  logic push_valid, push_done, is_term, is_erase, nl_end, msg_take, line_q;

  // Unrecognised terminator codes never end a line
  always_comb
  begin
    case (nlsel_q.in_nl)
      tml_pkg::INL_CR: is_term = (ch_q == tml_pkg::CH_CR);
      tml_pkg::INL_NUL: is_term = (ch_q == tml_pkg::CH_NUL);
      default: is_term = 1'b0;
    endcase
  end
  assign is_erase = ctrl_q.edit_en &&
    (ch_q == tml_pkg::CH_BKSP || ch_q == tml_pkg::CH_DEL);
  assign nl_end = ({1'b0, nl_len(nlsel_q.out_nl)} <= idx_q);
  assign msg_take = msg_valid_i & msg_ready_o;
  assign rx_ready_o = (state_q == tml_pkg::ST_IDLE);
  // Console input has priority over outgoing message text
  assign msg_ready_o = (state_q == tml_pkg::ST_IDLE) & ~rx_valid_i & buf_in_ready;

  always_comb
  begin
    push_valid = 1'b0;
    push_data = ch_q;
    case (state_q)
      tml_pkg::ST_IDLE:
      begin
        push_valid = msg_take;
        push_data = msg_data_i;
      end
      tml_pkg::ST_CHAR:
      begin
        if (is_erase)
        begin
          push_valid = (ctrl_q.del_mode == tml_pkg::DEL_SEND_DEL);
          push_data = tml_pkg::CH_DEL;
        end
        else
          push_valid = ctrl_q.echo_en && !is_term;
      end
      tml_pkg::ST_ERASE:
      begin
        push_valid = 1'b1;
        push_data = (idx_q == 3'h1) ? tml_pkg::CH_SP : tml_pkg::CH_BKSP;
      end
      tml_pkg::ST_MARK:
      begin
        push_valid = 1'b1;
        push_data = tml_pkg::MARK_CHARS[8 * (4 - idx_q) +: 8];
      end
      tml_pkg::ST_ECHO_NL, tml_pkg::ST_MARK_NL, tml_pkg::ST_MSG_NL:
      begin
        push_valid = !nl_end;
        push_data = nl_char(nlsel_q.out_nl, idx_q);
      end
      default: push_valid = 1'b0;
    endcase
  end
  assign push_done = push_valid & buf_in_ready;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ch_q <= 8'h00;
    else if (rx_valid_i && rx_ready_o)
      ch_q <= rx_data_i;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= tml_pkg::ST_IDLE;
      idx_q <= 3'h0;
    end
    else
    begin
      case (state_q)
        tml_pkg::ST_IDLE:
        begin
          idx_q <= 3'h0;
          if (rx_valid_i)
            state_q <= tml_pkg::ST_CHAR;
          else if (msg_take && msg_last_i)
            state_q <= tml_pkg::ST_MSG_NL;
        end
        tml_pkg::ST_CHAR:
        begin
          if (is_term && ctrl_q.echo_en)
            state_q <= tml_pkg::ST_ECHO_NL;
          else if (is_term && ctrl_q.ready_en)
            state_q <= tml_pkg::ST_MARK;
          else if (is_erase && ctrl_q.del_mode == tml_pkg::DEL_SEND_ERASE)
            state_q <= tml_pkg::ST_ERASE;
          else if (!push_valid || push_done)
            state_q <= tml_pkg::ST_IDLE;
        end
        tml_pkg::ST_ERASE:
        begin
          if (push_done)
            idx_q <= idx_q + 3'h1;
          if (push_done && idx_q == 3'h2)
            state_q <= tml_pkg::ST_IDLE;
        end
        tml_pkg::ST_MARK:
        begin
          if (push_done)
          begin
            idx_q <= (idx_q == 3'(MARK_LAST)) ? 3'h0 : idx_q + 3'h1;
            if (idx_q == 3'(MARK_LAST))
              state_q <= tml_pkg::ST_MARK_NL;
          end
        end
        tml_pkg::ST_ECHO_NL, tml_pkg::ST_MARK_NL, tml_pkg::ST_MSG_NL:
        begin
          if (nl_end)
          begin
            idx_q <= 3'h0;
            if (state_q == tml_pkg::ST_ECHO_NL && ctrl_q.ready_en)
              state_q <= tml_pkg::ST_MARK;
            else
              state_q <= tml_pkg::ST_IDLE;
          end
          else if (push_done)
            idx_q <= idx_q + 3'h1;
        end
        default: state_q <= tml_pkg::ST_IDLE;
      endcase
    end
  end

  // Line counter and completion pulse
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lines_q <= 8'h00;
      line_q <= 1'b0;
    end
    else
    begin
      line_q <= (state_q == tml_pkg::ST_CHAR) && is_term;
      if ((state_q == tml_pkg::ST_CHAR) && is_term)
        lines_q <= lines_q + 8'h01;
    end
  end
  assign line_done_o = line_q;

  // ****************************************************************
  // Two-entry output buffer
  // ****************************************************************
  // Absorbs a stall of the transmitter without dropping a byte
  logic [7:0] mem_q [2];
  logic wptr_q, rptr_q, pop;
  logic [1:0] cnt_q;
  assign buf_in_ready = (cnt_q != 2'h2);
  assign buf_out_valid = (cnt_q != 2'h0);
  assign pop = buf_out_valid & tx_ready_i;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wptr_q <= 1'b0;
      rptr_q <= 1'b0;
      cnt_q <= 2'h0;
      mem_q[0] <= 8'h00;
      mem_q[1] <= 8'h00;
    end
    else
    begin
      if (push_done)
      begin
        mem_q[wptr_q] <= push_data;
        wptr_q <= ~wptr_q;
      end
      if (pop)
        rptr_q <= ~rptr_q;
      cnt_q <= cnt_q + {1'b0, push_done} - {1'b0, pop};
    end
  end

  assign tx_data_o = mem_q[rptr_q];
  assign tx_valid_o = buf_out_valid;

endmodule // tml_line_handler

/* File: tb/tml_line_handler_chk.sv */
// Port checker for the terminal mode line handler.
// Assumes one clock, synchronous active-high reset; bound to the top module.
`timescale 1ns/1ps

module tml_line_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  input wire logic rx_ready_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic line_done_o
);
  // ****************************************************************
  // Register shadow and properties
  // ****************************************************************
  logic [7:0] lc_q;
  logic [7:0] nl_q;
  logic acc;
  logic prn;
  logic term;
  assign acc = rx_valid_i && rx_ready_o;
  assign prn = rx_data_i >= 8'h20 && rx_data_i != 8'h7F;
  assign term = (nl_q[3:0] == 4'h1 && rx_data_i == 8'h0D) ||
    (nl_q[3:0] == 4'h2 && rx_data_i == 8'h00);
  // Shadow follows only acknowledged writes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lc_q <= tml_pkg::LINE_CTRL_RESET;
      nl_q <= tml_pkg::NL_SEL_RESET;
    end
    else if (wb_ack_o && wb_stb_i && wb_we_i && wb_sel_i[0])
    begin
      if (wb_adr_i == tml_pkg::ADDR_LINE_CTRL)
        lc_q <= wb_dat_i[7:0] & tml_pkg::LINE_CTRL_MASK;
      if (wb_adr_i == tml_pkg::ADDR_NL_SEL)
        nl_q <= wb_dat_i[7:0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack late");
  property p_rd_ctrl;
    wb_ack_o && !wb_we_i && wb_adr_i == 4'h0 |-> wb_dat_o == {24'h000000, lc_q};
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("line control readback");
  property p_tx_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx word lost in stall");
  property p_echo;
    acc && prn && lc_q[1] && !tx_valid_o |-> ##2 tx_valid_o && tx_data_o == $past(rx_data_i, 2);
  endproperty
  a_echo: assert property (p_echo) else $error("echo missing");
  property p_no_echo; acc && prn && !lc_q[1] && !tx_valid_o |=> (!tx_valid_o) [*2]; endproperty
  a_no_echo: assert property (p_no_echo) else $error("echo while disabled");
  property p_erase;
    acc && lc_q[5] && lc_q[3:2] == 2'h0 && (rx_data_i == 8'h08 || rx_data_i == 8'h7F) &&
      !tx_valid_o |-> ##2 tx_valid_o && tx_data_o == 8'h7F;
  endproperty
  a_erase: assert property (p_erase) else $error("delete response");
  // Erase sequence starts one cycle later, after the state change
  property p_erase_seq;
    acc && lc_q[5] && lc_q[3:2] == 2'h1 && (rx_data_i == 8'h08 || rx_data_i == 8'h7F) &&
      !tx_valid_o |-> ##3 tx_valid_o && tx_data_o == 8'h08;
  endproperty
  a_erase_seq: assert property (p_erase_seq) else $error("erase sequence start");
  property p_term; acc && term |-> ##[1:3] line_done_o; endproperty
  a_term: assert property (p_term) else $error("terminator not seen");
endmodule // tml_line_chk

bind tml_line_handler tml_line_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_data_i, .rx_valid_i, .rx_ready_o,
  .tx_data_o, .tx_valid_o, .tx_ready_i, .line_done_o);

/* File: tb/tml_console_model.sv */
// Console model: sends characters and collects everything written to it.
// Assumes stall_i comes from the bench; a stall must not lose any word.
`timescale 1ns/1ps

module tml_console_model (
  input wire logic clk_i,
  input wire logic stall_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i
);
  logic [7:0] got[$];
  initial
  begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
  end
  assign tx_ready_o = !stall_i;
  always @(posedge clk_i)
    if (tx_valid_i && tx_ready_o)
      got.push_back(tx_data_i);
  // Terminator choice is the caller's; released data is inverted
  task automatic send(input logic [7:0] c);
    rx_valid_o <= 1'b1;
    rx_data_o <= c;
    do @(posedge clk_i); while (rx_ready_i !== 1'b1);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~c;
    @(posedge clk_i);
  endtask
endmodule // tml_console_model

/* File: tb/tml_line_handler_tb.sv */
// Self-checking bench for the terminal mode line handler.
// Assumes the console model drains tx and sources rx; 40 MHz clock.
`timescale 1ns/1ps

module tml_line_handler_tb;
  logic clk_i = 1'b0;
  logic rst_i;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [3:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [7:0] rx_data_i;
  logic rx_valid_i;
  logic rx_ready_o;
  logic [7:0] msg_data_i;
  logic msg_last_i;
  logic msg_valid_i;
  logic msg_ready_o;
  logic [7:0] tx_data_o;
  logic tx_valid_o;
  logic tx_ready_i;
  logic line_done_o;
  logic stall;
  logic [7:0] exp[$];
  int error_cnt = 0;
  int total_checks = 0;

  tml_line_handler dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_data_i, .rx_valid_i, .rx_ready_o, .msg_data_i,
    .msg_last_i, .msg_valid_i, .msg_ready_o, .tx_data_o, .tx_valid_o, .tx_ready_i, .line_done_o);
  tml_console_model con (.clk_i, .stall_i(stall), .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o),
    .tx_ready_o(tx_ready_i), .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i), .rx_ready_i(rx_ready_o));

  // ****************************************************************
  // Bus, compare and scenario tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] s, input logic [3:0] a,
    input logic [7:0] d, output logic [31:0] r);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= s;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb(1'b1, 4'hF, a, d, r);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, 4'hF, a, 8'h00, r);
    chk(r, e);
  endtask
  function automatic void add_nl(input logic [3:0] c);
    case (c)
      4'h1: exp = {exp, 8'h0D, 8'h0A};
      4'h2: exp.push_back(8'h00);
      4'h3: exp.push_back(8'h0D);
      4'h4: exp = {exp, 8'h0A, 8'h0D};
      4'h5: exp.push_back(8'h0A);
      default: ;
    endcase
  endfunction
  // Extra cycles catch late stray output
  task automatic expect_tx();
    repeat (4) @(posedge clk_i);
    while (con.got.size() < exp.size() || tx_valid_o || !rx_ready_o)
      @(posedge clk_i);
    chk(con.got.size(), exp.size());
    foreach (exp[i])
      if (i < con.got.size())
        chk(con.got[i], exp[i]);
    con.got.delete();
    exp.delete();
  endtask
  task automatic t_regs();
    logic [31:0] r;
    rdchk(tml_pkg::ADDR_LINE_CTRL, 32'h00000027);
    rdchk(tml_pkg::ADDR_NL_SEL, 32'h00000011);
    wr(tml_pkg::ADDR_LINE_CTRL, 8'hFF);
    rdchk(tml_pkg::ADDR_LINE_CTRL, 32'h0000002F);
    // Byte lane 0 off: the write must not land
    wb(1'b1, 4'hE, tml_pkg::ADDR_LINE_CTRL, 8'h00, r);
    rdchk(tml_pkg::ADDR_LINE_CTRL, 32'h0000002F);
    rdchk(4'hC, 32'h00000000);
    wr(tml_pkg::ADDR_LINE_CTRL, 8'h27);
  endtask
  task automatic t_echo();
    con.send(8'h41);
    exp = {8'h41};
    expect_tx();
    wr(tml_pkg::ADDR_LINE_CTRL, 8'h25);
    con.send(8'h42);
    expect_tx();
  endtask
  task automatic t_delete();
    wr(tml_pkg::ADDR_LINE_CTRL, 8'h20);
    con.send(8'h7F);
    exp = {8'h7F};
    expect_tx();
    wr(tml_pkg::ADDR_LINE_CTRL, 8'h24);
    con.send(8'h08);
    exp = {8'h08, 8'h20, 8'h08};
    expect_tx();
    wr(tml_pkg::ADDR_LINE_CTRL, 8'h28);
    con.send(8'h7F);
    expect_tx();
    wr(tml_pkg::ADDR_LINE_CTRL, 8'h02);
    con.send(8'h08);
    exp = {8'h08};
    expect_tx();
  endtask
  task automatic t_term();
    wr(tml_pkg::ADDR_LINE_CTRL, 8'h27);
    for (int c = 0; c < 6; c++)
    begin
      wr(tml_pkg::ADDR_NL_SEL, {c[3:0], 4'h1});
      con.send(8'h0D);
      add_nl(c[3:0]);
      exp = {exp, 8'h5B, 8'h53, 8'h59, 8'h53, 8'h5D};
      add_nl(c[3:0]);
      expect_tx();
    end
    wr(tml_pkg::ADDR_LINE_CTRL, 8'h25);
    wr(tml_pkg::ADDR_NL_SEL, 8'h12);
    con.send(8'h00);
    exp = {8'h5B, 8'h53, 8'h59, 8'h53, 8'h5D, 8'h0D, 8'h0A};
    expect_tx();
    // Seven terminators so far, block idle and drained
    rdchk(tml_pkg::ADDR_STATUS, 32'h00000700);
  endtask
  // Console stalls so the two-entry buffer fills mid-line
  task automatic t_msg();
    logic [7:0] m[3] = '{8'h48, 8'h49, 8'h21};
    wr(tml_pkg::ADDR_NL_SEL, 8'h41);
    stall <= 1'b1;
    fork
      begin
        repeat (12) @(posedge clk_i);
        stall <= 1'b0;
      end
    join_none
    for (int i = 0; i < 3; i++)
    begin
      msg_data_i <= m[i];
      msg_last_i <= (i == 2);
      msg_valid_i <= 1'b1;
      do @(posedge clk_i); while (msg_ready_o !== 1'b1);
    end
    msg_valid_i <= 1'b0;
    msg_last_i <= 1'b0;
    msg_data_i <= ~m[2];
    exp = {m[0], m[1], m[2], 8'h0A, 8'h0D};
    expect_tx();
  endtask
  task automatic complete_run();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial forever #12.5 clk_i = ~clk_i;
  initial
  begin
    rst_i <= 1'b1;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    wb_adr_i <= 4'h0;
    wb_sel_i <= 4'hF;
    wb_dat_i <= 32'h00000000;
    msg_data_i <= 8'h00;
    msg_last_i <= 1'b0;
    msg_valid_i <= 1'b0;
    stall <= 1'b0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_echo();
    t_delete();
    t_term();
    t_msg();
    complete_run();
  end
  // Whole run needs well under a thousand cycles
  initial
  begin
    #(25 * 4000);
    error_cnt++;
    complete_run();
  end
endmodule // tml_line_handler_tb
